// file: src/tdr_responder.sv
// TCP diagnostics responder: parses requests and streams replies
`timescale 1ns/1ns
module tdr_responder (
  input  wire logic                clock_in,
  input  wire logic                rst_in,
  input  wire tdr_pkg::tdr_byte_t  req_in,
  output logic                     req_ready_out,
  output tdr_pkg::tdr_byte_t       rsp_out,
  input  wire logic                rsp_ready_in,
  input  wire logic                frame_err_in,
  input  wire logic                overflow_in,
  input  wire logic [31:0]         host_ip_in
);
  import tdr_pkg::*;

  typedef enum logic {TDR_RECV, TDR_SEND} tdr_state_t;

  tdr_state_t  state_r,    state_nxt;
  logic [7:0]  buf_r [5],  buf_nxt [5];
  logic [2:0]  rcnt_r,     rcnt_nxt;
  logic        call_r,     call_nxt;
  logic [6:0]  idx_r,      idx_nxt;
  logic [6:0]  pos_r,      pos_nxt;
  logic [31:0] snap_frm_r, snap_frm_nxt;
  logic [31:0] snap_ovf_r, snap_ovf_nxt;
  tdr_byte_t   rsp_r,      rsp_nxt;
  logic        rdy_r,      rdy_nxt;
  logic [31:0] frm_cnt;
  logic [31:0] ovf_cnt;
  logic        take;
  logic        fin;
  logic        hdr_ok;
  logic        acc_call;
  logic        acc_reset;
  logic        load;
  logic [6:0]  len;

  // Pick one byte of a big-endian word
  function automatic logic [7:0] word_byte(input logic [31:0] w,
                                           input logic [1:0]  sel);
    word_byte = w[8*(3-sel) +: 8];
  endfunction

  // Byte at a given reply position
  function automatic logic [7:0] reply_byte(input logic [6:0]  p,
                                            input logic        call,
                                            input logic [31:0] frm,
                                            input logic [31:0] ovf,
                                            input logic [31:0] ip);
    logic [15:0] tail;
    tail = call ? TDR_OP_STAT : TDR_DATA_RESET;
    reply_byte = 8'h00;
    if (p == 7'h00) begin
      reply_byte = TDR_FC_DIAG;
    end else if (p == 7'h01) begin
      reply_byte = TDR_SUB_TCP[15:8];
    end else if (p == 7'h02) begin
      reply_byte = TDR_SUB_TCP[7:0];
    end else if (p == TDR_OFS_OPSTAT) begin
      reply_byte = tail[15:8];
    end else if (p == TDR_OFS_OPSTAT + 7'h01) begin
      reply_byte = tail[7:0];
    end else if (p >= TDR_OFS_FRMERR && p < TDR_OFS_OVFERR) begin
      reply_byte = word_byte(frm, 2'(p - TDR_OFS_FRMERR));
    end else if (p >= TDR_OFS_OVFERR && p < TDR_OFS_RXZERO) begin
      reply_byte = word_byte(ovf, 2'(p - TDR_OFS_OVFERR));
    end else if (p >= TDR_OFS_HOSTIP) begin
      reply_byte = word_byte(ip, 2'(p - TDR_OFS_HOSTIP));
    end
  endfunction

  // Error counters for the reception statistics
  tdr_event_counter u_frm_cnt (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .clear_in  (acc_reset),
    .event_in  (frame_err_in),
    .count_out (frm_cnt)
  );

  tdr_event_counter u_ovf_cnt (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .clear_in  (acc_reset),
    .event_in  (overflow_in),
    .count_out (ovf_cnt)
  );

  // Request decode
  always_comb begin
    take   = req_in.valid && rdy_r;
    fin    = take && req_in.last && rcnt_r == TDR_REQ_LEN - 3'h1;
    hdr_ok = buf_r[0] == TDR_FC_DIAG &&
             {buf_r[1], buf_r[2]} == TDR_SUB_TCP;
    acc_call  = fin && hdr_ok && {buf_r[3], req_in.data} == TDR_DATA_CALL;
    acc_reset = fin && hdr_ok && {buf_r[3], req_in.data} == TDR_DATA_RESET;
    load      = state_r == TDR_SEND && (!rsp_r.valid || rsp_ready_in);
    len       = call_r ? TDR_CALL_LEN : TDR_RESET_LEN;
  end

  // Next-state logic for receive and send
  always_comb begin
    state_nxt    = state_r;
    buf_nxt      = buf_r;
    rcnt_nxt     = rcnt_r;
    call_nxt     = call_r;
    idx_nxt      = idx_r;
    pos_nxt      = pos_r;
    snap_frm_nxt = snap_frm_r;
    snap_ovf_nxt = snap_ovf_r;
    rsp_nxt      = rsp_r;
    if (rsp_r.valid && rsp_ready_in) begin
      rsp_nxt.valid = 1'b0;
    end
    if (take) begin
      if (rcnt_r < TDR_REQ_LEN) begin
        buf_nxt[rcnt_r] = req_in.data;
        rcnt_nxt        = rcnt_r + 3'h1;
      end
      if (req_in.last) begin
        rcnt_nxt = 3'h0;
      end
    end
    if (acc_call || acc_reset) begin
      state_nxt    = TDR_SEND;
      call_nxt     = acc_call;
      idx_nxt      = TDR_POS_RESET;
      snap_frm_nxt = frm_cnt;
      snap_ovf_nxt = ovf_cnt;
    end
    // fixed reply layout streamed by position
    if (load) begin
      rsp_nxt.valid = 1'b1;
      rsp_nxt.data  = reply_byte(idx_r, call_r, snap_frm_r,
                                 snap_ovf_r, host_ip_in);
      rsp_nxt.last  = idx_r == len - 7'h01;
      pos_nxt       = idx_r;
      idx_nxt       = idx_r + 7'h01;
      if (idx_r == len - 7'h01) begin
        state_nxt = TDR_RECV;
      end
    end
    rdy_nxt = state_nxt == TDR_RECV;
  end

  // State registers
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r    <= TDR_RECV;
      buf_r      <= '{default: 8'h00};
      rcnt_r     <= 3'h0;
      call_r     <= 1'b0;
      idx_r      <= TDR_POS_RESET;
      pos_r      <= TDR_POS_RESET;
      snap_frm_r <= TDR_CNT_RESET;
      snap_ovf_r <= TDR_CNT_RESET;
      rsp_r      <= '0;
      rdy_r      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      buf_r      <= buf_nxt;
      rcnt_r     <= rcnt_nxt;
      call_r     <= call_nxt;
      idx_r      <= idx_nxt;
      pos_r      <= pos_nxt;
      snap_frm_r <= snap_frm_nxt;
      snap_ovf_r <= snap_ovf_nxt;
      rsp_r      <= rsp_nxt;
      rdy_r      <= rdy_nxt;
    end
  end

  assign req_ready_out = rdy_r;
  assign rsp_out       = rsp_r;

  // Checks on the reply stream
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // call request starts a call reply
  call_start_a: assert property (acc_call |=>
    state_r == TDR_SEND && call_r)
    else $error("call request not answered");

  // Call reply header, most significant byte first
  localparam logic [39:0] TDR_CALL_HDR = {TDR_FC_DIAG, TDR_SUB_TCP,
                                          TDR_OP_STAT};

  call_hdr_a: assert property (rsp_r.valid && call_r &&
    pos_r < TDR_OFS_FUNERR |->
    rsp_r.data == TDR_CALL_HDR[8 * (TDR_OFS_OPSTAT + 7'h01 - pos_r) +: 8])
    else $error("call reply header wrong");

  fun_zero_a: assert property (rsp_r.valid && call_r &&
    pos_r >= TDR_OFS_FUNERR && pos_r < TDR_OFS_FRMERR |-> rsp_r.data == 8'h00)
    else $error("function error bytes not zero");

  frm_bytes_a: assert property (rsp_r.valid && call_r &&
    pos_r >= TDR_OFS_FRMERR && pos_r < TDR_OFS_OVFERR |->
    rsp_r.data == word_byte(snap_frm_r, 2'(pos_r - TDR_OFS_FRMERR)))
    else $error("frame error count byte wrong");

  ovf_bytes_a: assert property (rsp_r.valid && call_r &&
    pos_r >= TDR_OFS_OVFERR && pos_r < TDR_OFS_TXZERO |->
    rsp_r.data == (pos_r < TDR_OFS_RXZERO ?
    word_byte(snap_ovf_r, 2'(pos_r - TDR_OFS_OVFERR)) : 8'h00))
    else $error("overflow section wrong");

  // host IP closes the call reply
  ip_tail_a: assert property (rsp_r.valid && call_r &&
    pos_r == TDR_CALL_LEN - 7'h01 |->
    rsp_r.last && rsp_r.data == host_ip_in[7:0])
    else $error("host address tail wrong");

  // echo is five bytes ending in 04
  echo_end_a: assert property (rsp_r.valid && !call_r &&
    rsp_r.last |->
    pos_r == TDR_RESET_LEN - 7'h01 && rsp_r.data == TDR_DATA_RESET[7:0])
    else $error("reset echo wrong");

  cnt_clear_a: assert property (acc_reset |=>
    frm_cnt == {31'h0, $past(frame_err_in)} &&
    ovf_cnt == {31'h0, $past(overflow_in)})
    else $error("counters not cleared");

  call_seen_c:  cover property (acc_call ##[1:300] rsp_r.valid && rsp_r.last);
  reset_seen_c: cover property (acc_reset ##[1:20] rsp_r.valid && rsp_r.last);
  stall_c:      cover property (rsp_r.valid && !rsp_ready_in [*3]);
  reject_c:     cover property (fin && !acc_call && !acc_reset);

endmodule

// file: src/tdr_pkg.sv
// Shared constants and carrier types for the TCP diagnostics responder
package tdr_pkg;

  // Request and reply fields
  localparam logic [7:0]  TDR_FC_DIAG    = 8'h08;
  localparam logic [15:0] TDR_SUB_TCP    = 16'h0015;
  localparam logic [15:0] TDR_DATA_CALL  = 16'h0003;
  localparam logic [15:0] TDR_DATA_RESET = 16'h0004;
  localparam logic [15:0] TDR_OP_STAT    = 16'h0003;

  // Frame lengths in bytes
  localparam logic [2:0]  TDR_REQ_LEN    = 3'h5;
  localparam logic [6:0]  TDR_RESET_LEN  = 7'h05;
  localparam logic [6:0]  TDR_CALL_LEN   = 7'h41;

  // Byte positions inside the call-state reply
  localparam logic [6:0]  TDR_OFS_OPSTAT = 7'h03;
  localparam logic [6:0]  TDR_OFS_FUNERR = 7'h05;
  localparam logic [6:0]  TDR_OFS_FRMERR = 7'h19;
  localparam logic [6:0]  TDR_OFS_OVFERR = 7'h1D;
  localparam logic [6:0]  TDR_OFS_RXZERO = 7'h21;
  localparam logic [6:0]  TDR_OFS_TXZERO = 7'h29;
  localparam logic [6:0]  TDR_OFS_HOSTIP = 7'h3D;

  // Reset values
  localparam logic [31:0] TDR_CNT_RESET  = 32'h0000_0000;
  localparam logic [6:0]  TDR_POS_RESET  = 7'h00;

  // One byte of a frame on either stream
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } tdr_byte_t;

endpackage

// file: src/tdr_event_counter.sv
// Saturating 32-bit event counter with synchronous clear
`timescale 1ns/1ns
module tdr_event_counter (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        clear_in,
  input  wire logic        event_in,
  output logic [31:0]      count_out
);
  import tdr_pkg::*;

  logic [31:0] count_r;
  logic [31:0] count_nxt;

  // Clear then count, so an event in the clear cycle survives
  always_comb begin
    count_nxt = clear_in ? TDR_CNT_RESET : count_r;
    if (event_in && count_nxt != 32'hFFFF_FFFF) begin
      count_nxt = count_nxt + 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      count_r <= TDR_CNT_RESET;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count_out = count_r;

endmodule

// file: tb/tdr_client_sink.sv
// Reply sink model of the diagnostics client, with stalls
`timescale 1ns/1ns
module tdr_client_sink (
  input  wire logic               clock_in,
  input  wire logic               rst_in,
  input  wire logic               stall_in,
  input  wire tdr_pkg::tdr_byte_t rsp_in,
  output logic                    ready_out
);
  import tdr_pkg::*;
  logic ready_r;
  logic ready_nxt;
  // Accept reply bytes unless told to stall; ready while idle
  always_comb begin
    ready_nxt = !stall_in || !rsp_in.valid;
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= ready_nxt;
    end
  end
  assign ready_out = ready_r;
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the TCP diagnostics responder
`timescale 1ns/1ns
module tb_top;
  import tdr_pkg::*;
  logic        clock_in     = 1'b0;
  logic        rst_in       = 1'b1;
  tdr_byte_t   req_in       = '0;
  tdr_byte_t   rsp_out;
  logic        req_ready_out;
  logic        rsp_ready_in;
  logic        frame_err_in = 1'b0;
  logic        overflow_in  = 1'b0;
  logic        stall        = 1'b0;
  logic [31:0] host_ip_in   = 32'h0;
  logic [7:0]  lfsr         = 8'h47;
  logic [8:0]  exp_q[$];
  int          n_errors     = 0;
  int          tests_run    = 0;

  initial begin
    forever #2 clock_in = ~clock_in;
  end

  tdr_responder dut (.clock_in(clock_in), .rst_in(rst_in),
    .req_in(req_in), .req_ready_out(req_ready_out), .rsp_out(rsp_out),
    .rsp_ready_in(rsp_ready_in), .frame_err_in(frame_err_in),
    .overflow_in(overflow_in), .host_ip_in(host_ip_in));
  tdr_client_sink sink (.clock_in(clock_in), .rst_in(rst_in),
    .stall_in(stall), .rsp_in(rsp_out), .ready_out(rsp_ready_in));

  function automatic logic [7:0] lfsr_next(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(string name, logic [8:0] seen, logic [8:0] want);
    tests_run++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
    end
  endtask

  task automatic print_verdict();
    $display("Errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Note the first n bytes of a frame as expected replies
  task automatic push(logic [519:0] f, int n);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({f[519-8*i -: 8], i == n - 1});
    end
  endtask

  // Request frame: function, sub-function, data, MSB first
  // request format
  task automatic send(logic [15:0] data_word);
    logic [39:0] f;
    int          k;
    f = {TDR_FC_DIAG, TDR_SUB_TCP, data_word};
    for (int i = 0; i < 5; i++) begin
      req_in <= '{1'b1, f[39-8*i -: 8], i == 4};
      k = 0;
      do begin
        @(negedge clock_in);
        k++;
      end while (req_ready_out !== 1'b1 && k < 2000);
      if (k >= 2000) begin
        n_errors++;
        print_verdict();
      end
      @(posedge clock_in);
    end
    req_in <= '0;
    @(negedge clock_in);
    check("req_ready", {8'h00, req_ready_out},
          {8'h00, data_word != TDR_DATA_CALL &&
                  data_word != TDR_DATA_RESET});
  endtask

  // Wait until every noted reply byte has been seen
  task automatic drain();
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 3000) begin
      @(posedge clock_in);
      k++;
    end
    if (k >= 3000) begin
      n_errors++;
      print_verdict();
    end
    repeat (3) @(posedge clock_in);
  endtask

  task automatic pulse(logic f, logic o);
    frame_err_in <= f;
    overflow_in  <= o;
    @(posedge clock_in);
    frame_err_in <= 1'b0;
    overflow_in  <= 1'b0;
    @(posedge clock_in);
  endtask

  // Random sink stalls from the shift register
  always @(posedge clock_in) begin
    lfsr  <= lfsr_next(lfsr);
    stall <= lfsr[0] & lfsr[2];
  end

  // Compare each taken reply byte with the oldest note
  always @(posedge clock_in) begin
    if (!rst_in && rsp_out.valid === 1'b1 && rsp_ready_in === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected_reply", 9'h000, 9'h1FF);
      end else begin
        check("reply_byte", {rsp_out.data, rsp_out.last},
              exp_q.pop_front());
      end
    end
  end

  initial begin
    logic [31:0] ip;
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    ip = {lfsr, lfsr_next(lfsr), 16'hA801};
    host_ip_in <= ip;
    @(posedge clock_in);
    // Call with cleared counters
    // reply layout
    push({TDR_FC_DIAG, TDR_SUB_TCP, TDR_OP_STAT, 160'h0, 64'h0,
          64'h0, 160'h0, ip}, 65);
    send(TDR_DATA_CALL);
    drain();
    // Three frame errors and two overflows
    // counters in reply
    for (int i = 0; i < 3; i++) begin
      pulse(1'b1, i < 2);
    end
    push({TDR_FC_DIAG, TDR_SUB_TCP, TDR_OP_STAT, 160'h0, 32'h3,
          32'h2, 64'h0, 160'h0, ip}, 65);
    send(TDR_DATA_CALL);
    drain();
    // Unknown data word gets no reply
    send(16'h0005);
    repeat (30) @(posedge clock_in);
    push({TDR_FC_DIAG, TDR_SUB_TCP, TDR_DATA_RESET, 480'h0}, 5);
    send(TDR_DATA_RESET);
    drain();
    push({TDR_FC_DIAG, TDR_SUB_TCP, TDR_OP_STAT, 160'h0, 64'h0,
          64'h0, 160'h0, ip}, 65);
    send(TDR_DATA_CALL);
    drain();
    print_verdict();
  end
endmodule
